// ### include/afct_pkg.sv
// Package for the automatic flow-control trigger: register map, fields, timing constants and carriers
`default_nettype none
package afct_pkg;

    // Register map (byte addresses on the Wishbone slave)
    localparam logic [7:0]  ADDR_CONFIG     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam logic [31:0] CONFIG_RESET    = 32'h0000_0000;
    localparam logic [31:0] CONFIG_WMASK    = 32'h00FF_FFFF;

    // Field positions of flow_control_config
    localparam int TRIG_HI_POS   = 16;
    localparam int RESUME_LO_POS = 8;
    localparam int DUR_POS       = 4;
    localparam int BIT_MCAST     = 3;
    localparam int BIT_BCAST     = 2;
    localparam int BIT_ADDR      = 1;
    localparam int BIT_ANY       = 0;

    // Threshold unit: one count is 64 bytes of receive FIFO occupancy
    localparam int THRESH_UNIT_SHIFT = 6;
    localparam int FIFO_LEVEL_W      = 16;

    // Clock period and slow-speed extra in nanoseconds, duration counter width in bits
    localparam int CLK_PERIOD_NS   = 100;
    localparam int SLOW_EXTRA_NS   = 2200;
    localparam int DUR_CNT_W       = 14;

    // Status bit positions
    localparam int STS_BP_POS      = 0;
    localparam int STS_ABOVE_POS   = 1;
    localparam int STS_PAUSED_POS  = 2;

    // Per-frame event carrier from the receive MAC
    typedef struct packed {
        logic preamble;   // Valid preamble seen, start of frame
        logic addr_valid; // Destination address decoded this cycle
        logic multicast;
        logic broadcast;
        logic addr_match;
    } afct_rx_evt_t;

    // Pause request carrier toward the transmit MAC
    typedef struct packed {
        logic req;
        logic zero_time;
    } afct_pause_t;

endpackage : afct_pkg

`default_nettype wire

// ### rtl/afct_bp_timer.sv
// Back-pressure duration timer: maps code and speed to a cycle count and counts it down
`timescale 1ns/100ps
`default_nettype none

module afct_bp_timer (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // Control
    input  wire logic       i_start,
    input  wire logic       i_abort,
    input  wire logic [3:0] i_code,
    input  wire logic       i_speed_100,
    // State
    output logic            o_active
);

    logic [afct_pkg::DUR_CNT_W-1:0] cnt_q;

    // Duration in ns for the 100 Mb/s column
    function automatic int dur_ns_100(input logic [3:0] code);
        unique case (code)
            4'h0:    dur_ns_100 = 5000;
            4'h1:    dur_ns_100 = 10000;
            4'h2:    dur_ns_100 = 15000;
            4'h3:    dur_ns_100 = 25000;
            4'h4:    dur_ns_100 = 50000;
            default: dur_ns_100 = (int'(code) - 3) * 50000; // see [RQ11]
        endcase
    endfunction : dur_ns_100

    // Cycle count, rounded down so the hold never exceeds the duration, and at least one
    function automatic logic [afct_pkg::DUR_CNT_W-1:0] dur_cycles(input logic [3:0] code, input logic fast);
        int ns;
        int cyc;
        ns  = dur_ns_100(code) + (fast ? 0 : afct_pkg::SLOW_EXTRA_NS); // see [RQ12]
        cyc = ns / afct_pkg::CLK_PERIOD_NS;
        if (cyc < 1) begin
            cyc = 1;
        end
        dur_cycles = cyc[afct_pkg::DUR_CNT_W-1:0];
    endfunction : dur_cycles

    // Loaded from the mapped duration, ends when the count expires
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else if (i_abort) begin
            cnt_q <= '0;
        end else if (i_start) begin
            cnt_q <= dur_cycles(i_code, i_speed_100); // see [RQ17] see [RQ2]
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1; // see [RQ17]
        end
    end

    assign o_active = (cnt_q != '0);

endmodule : afct_bp_timer

`default_nettype wire

// ### rtl/afct_trigger.sv
// Automatic receive flow-control trigger with Wishbone register slave
//
// What this block does
// [RQ1] Software keeps resume threshold below trigger threshold
// [RQ2] Back pressure held for programmed duration code
// [RQ3] Duration field ignored in full duplex
// [RQ4] Multicast frame triggers back pressure, half duplex
// [RQ5] Broadcast frame triggers back pressure, half duplex
// [RQ6] Address-matched frame triggers back pressure, half duplex
// [RQ7] Any frame triggers; enables full-duplex pause
// [RQ8] Any-frame half duplex acts on preamble
// [RQ9] Full duplex: request pause immediately at level
// [RQ10] Any-frame bit overrides other trigger bits
// [RQ11] 100 Mb/s duration table from 5 us
// [RQ12] 10 Mb/s adds 2.2 us per code
// [RQ13] Thresholds eight bits in 64-byte units
// [RQ14] One pause frame per high crossing
// [RQ15] Zero-time pause once below low threshold
// [RQ16] Nothing sent while transmitter disabled
// [RQ17] Duration timed by system-clock counter
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module afct_trigger (
    // Clock and reset
    input  wire logic                                 i_clk_sys,
    input  wire logic                                 i_rst,
    // Wishbone classic slave
    input  wire logic                                 i_wb_cyc,
    input  wire logic                                 i_wb_stb,
    input  wire logic                                 i_wb_we,
    input  wire logic [7:0]                           i_wb_adr,
    input  wire logic [3:0]                           i_wb_sel,
    input  wire logic [31:0]                          i_wb_dat,
    output logic      [31:0]                          o_wb_dat,
    output logic                                      o_wb_ack,
    output logic                                      o_wb_err,
    // Link and MAC state
    input  wire logic                                 i_full_duplex,
    input  wire logic                                 i_speed_100,
    input  wire logic                                 i_tx_enable,
    input  wire logic [afct_pkg::FIFO_LEVEL_W-1:0]    i_rx_fifo_bytes,
    // Receive frame events
    input  wire afct_pkg::afct_rx_evt_t               i_rx_evt,
    // Pause request to the transmit MAC
    output afct_pkg::afct_pause_t                     o_pause,
    input  wire logic                                 i_pause_sent,
    // Half-duplex back pressure (jam) request
    output logic                                      o_backpressure
);

    logic [31:0] cfg_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        err_q;
    logic        above_q;
    logic        paused_q;
    logic        pause_req_q;
    logic        pause_zero_q;
    logic        bp_start;
    logic        bp_active;
    logic        bp_q;

    // Config fields
    logic [7:0] trig_hi;
    logic [7:0] resume_lo;
    logic [3:0] dur_code;
    logic       trig_any;
    logic       trig_mc;
    logic       trig_bc;
    logic       trig_am;

    assign trig_hi   = cfg_q[afct_pkg::TRIG_HI_POS +: 8];
    assign resume_lo = cfg_q[afct_pkg::RESUME_LO_POS +: 8];
    assign dur_code  = cfg_q[afct_pkg::DUR_POS +: 4];
    assign trig_any  = cfg_q[afct_pkg::BIT_ANY];
    assign trig_mc   = cfg_q[afct_pkg::BIT_MCAST];
    assign trig_bc   = cfg_q[afct_pkg::BIT_BCAST];
    assign trig_am   = cfg_q[afct_pkg::BIT_ADDR];

    // Occupancy in 64-byte units for comparison against thresholds
    logic [afct_pkg::FIFO_LEVEL_W-1:0] level_units;
    assign level_units = i_rx_fifo_bytes >> afct_pkg::THRESH_UNIT_SHIFT; // see [RQ13]

    logic at_high;
    logic below_low;
    logic auto_en;
    // Trigger level reached; a zero threshold counts as reached at once
    assign at_high   = (level_units >= {{(afct_pkg::FIFO_LEVEL_W-8){1'b0}}, trig_hi}); // see [RQ13]
    // Relies on software keeping low below high, else pause pairs may chatter
    assign below_low = (level_units <  {{(afct_pkg::FIFO_LEVEL_W-8){1'b0}}, resume_lo}); // see [RQ1]
    assign auto_en   = trig_any | trig_mc | trig_bc | trig_am;

    // ---------------- Wishbone slave ----------------
    logic req;
    logic hit_cfg;
    logic hit_sts;
    assign req     = i_wb_cyc & i_wb_stb & ~ack_q & ~err_q;
    assign hit_cfg = (i_wb_adr == afct_pkg::ADDR_CONFIG);
    assign hit_sts = (i_wb_adr == afct_pkg::ADDR_STATUS);

    // Byte-lane merge of a write into the config register
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        lane_merge = ((old_v & ~m) | (new_v & m)) & afct_pkg::CONFIG_WMASK;
    endfunction : lane_merge

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cfg_q <= afct_pkg::CONFIG_RESET;
        end else if (req && i_wb_we && hit_cfg) begin
            cfg_q <= lane_merge(cfg_q, i_wb_dat, i_wb_sel);
        end
    end

    // Ack one cycle after the request; unmapped addresses answer with err
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req & (hit_cfg | hit_sts);
            err_q <= req & ~(hit_cfg | hit_sts);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rdat_q <= 32'h0000_0000;
        end else if (req && !i_wb_we) begin
            if (hit_cfg) begin
                rdat_q <= cfg_q;
            end else if (hit_sts) begin
                rdat_q <= {29'h0000_0000, paused_q, above_q, bp_q};
            end else begin
                rdat_q <= 32'h0000_0000;
            end
        end
    end

    assign o_wb_dat = rdat_q;
    assign o_wb_ack = ack_q;
    assign o_wb_err = err_q;

    // ---------------- Level tracking ----------------
    // Hysteresis: armed at high, released below low
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            above_q <= 1'b0;
        end else if (at_high) begin
            above_q <= 1'b1;
        end else if (below_low) begin
            above_q <= 1'b0;
        end
    end

    // ---------------- Full-duplex pause requests ----------------
    logic fd_fire;
    logic fd_resume;
    // Only the any-frame bit enables full-duplex flow control
    assign fd_fire   = i_full_duplex & trig_any & i_tx_enable & at_high & ~paused_q & ~pause_req_q; // see [RQ7] see [RQ9]
    assign fd_resume = i_full_duplex & trig_any & i_tx_enable & paused_q & below_low & ~pause_req_q; // see [RQ15]

    // Pause request stands until the MAC reports the frame sent or the transmitter is disabled
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pause_req_q  <= 1'b0;
            pause_zero_q <= 1'b0;
        end else if (!i_tx_enable) begin
            pause_req_q  <= 1'b0; // see [RQ16]
            pause_zero_q <= 1'b0;
        end else if (pause_req_q && i_pause_sent) begin
            pause_req_q  <= 1'b0;
        end else if (fd_fire) begin
            pause_req_q  <= 1'b1; // see [RQ9]
            pause_zero_q <= 1'b0; // Pause time comes from the MAC's pause_time_setting, see [RQ14]
        end else if (fd_resume) begin
            pause_req_q  <= 1'b1; // see [RQ15]
            pause_zero_q <= 1'b1;
        end
    end

    // Remembers that a non-zero pause went out, so only one is sent per crossing
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            paused_q <= 1'b0;
        end else if (!trig_any || !i_full_duplex) begin
            paused_q <= 1'b0;
        end else if (pause_req_q && i_pause_sent) begin
            paused_q <= ~pause_zero_q; // see [RQ14] see [RQ15]
        end
    end

    assign o_pause.req       = pause_req_q;
    assign o_pause.zero_time = pause_zero_q;

    // ---------------- Half-duplex back pressure ----------------
    logic class_hit;
    // Any-frame acts on preamble without address decode and masks the class bits
    always_comb begin
        if (trig_any) begin
            class_hit = i_rx_evt.preamble; // see [RQ8] see [RQ10]
        end else begin
            class_hit = i_rx_evt.addr_valid &
                        ((trig_mc & i_rx_evt.multicast) |  // see [RQ4]
                         (trig_bc & i_rx_evt.broadcast) |  // see [RQ5]
                         (trig_am & i_rx_evt.addr_match)); // see [RQ6]
        end
    end

    // Class bits and duration take effect only in half duplex
    assign bp_start = ~i_full_duplex & i_tx_enable & auto_en & at_high & class_hit & ~bp_active; // see [RQ3] see [RQ7]

    afct_bp_timer u_bp_timer (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_start     (bp_start),
        .i_abort     (i_full_duplex | ~i_tx_enable),
        .i_code      (dur_code),
        .i_speed_100 (i_speed_100),
        .o_active    (bp_active)
    );

    // Registered so the jam output is glitch-free; lags the counter by one cycle
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bp_q <= 1'b0;
        end else begin
            bp_q <= bp_active & i_tx_enable & ~i_full_duplex; // see [RQ2] see [RQ16]
        end
    end

    assign o_backpressure = bp_q;

endmodule : afct_trigger

`default_nettype wire

// ### tb/afct_asserts.sv
// Port-level assertions for the flow-control trigger
`timescale 1ns/100ps
`default_nettype none
module afct_asserts (
    // Clock and reset
    input wire logic                   i_clk_sys,
    input wire logic                   i_rst,
    // Watched ports
    input wire logic                   i_wb_cyc,
    input wire logic                   i_wb_stb,
    input wire logic                   o_wb_ack,
    input wire logic                   o_wb_err,
    input wire logic                   i_full_duplex,
    input wire logic                   i_tx_enable,
    input wire afct_pkg::afct_rx_evt_t i_rx_evt,
    input wire afct_pkg::afct_pause_t  o_pause,
    input wire logic                   i_pause_sent,
    input wire logic                   o_backpressure
);
    logic [12:0] len_q;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // Length of the current jam, read at its falling edge
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            len_q <= 13'h0;
        end else begin
            len_q <= o_backpressure ? len_q + 13'h1 : 13'h0;
        end
    end
    chk_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err |=> o_wb_ack || o_wb_err)
        else $error("bus request not answered in one cycle");
    chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    chk_ack_err_excl: assert property (!(o_wb_ack && o_wb_err))
        else $error("ack and err together");
    chk_no_tx_jam: assert property (!i_tx_enable [*2] |-> !o_backpressure)
        else $error("jam while transmitter off");
    chk_no_tx_pause: assert property (!i_tx_enable [*2] |-> !o_pause.req)
        else $error("pause request while transmitter off");
    chk_fd_no_jam: assert property (i_full_duplex [*2] |-> !o_backpressure)
        else $error("jam in full duplex");
    chk_pause_drop: assert property (o_pause.req && i_pause_sent |=> !o_pause.req)
        else $error("pause request kept after sent");
    chk_jam_cause: assert property ($rose(o_backpressure) |->
        $past(i_rx_evt.preamble, 2) || $past(i_rx_evt.addr_valid, 2))
        else $error("jam without a frame event");
    chk_jam_min: assert property ($fell(o_backpressure) && i_tx_enable && !i_full_duplex |->
        len_q >= 13'h32)
        else $error("jam shorter than shortest duration");
endmodule : afct_asserts
`default_nettype wire

// ### tb/afct_mac_model.sv
// Far-side model: receive frame events and pause-frame transmission
`timescale 1ns/100ps
`default_nettype none
module afct_mac_model (
    // Clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst,
    // Bench control
    input  wire logic                   i_send,
    input  wire afct_pkg::afct_rx_evt_t i_evt,
    input  wire logic [2:0]             i_delay,
    // Toward the trigger
    output afct_pkg::afct_rx_evt_t      o_rx_evt,
    input  wire afct_pkg::afct_pause_t  i_pause,
    output logic                        o_pause_sent
);
    logic       busy_q;
    logic [2:0] wait_q;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rx_evt <= '0;
        end else begin
            o_rx_evt <= i_send ? i_evt : '0;
        end
    end
    // Waits for a transmit window; a withdrawn request is never answered
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            wait_q <= 3'h0;
            o_pause_sent <= 1'b0;
        end else begin
            o_pause_sent <= 1'b0;
            if (busy_q && !i_pause.req) begin
                busy_q <= 1'b0;
            end else if (busy_q && wait_q == 3'h0) begin
                busy_q <= 1'b0;
                o_pause_sent <= 1'b1;
            end else if (busy_q) begin
                wait_q <= wait_q - 3'h1;
            end else if (i_pause.req && !o_pause_sent) begin
                busy_q <= 1'b1;
                wait_q <= i_delay;
            end
        end
    end
endmodule : afct_mac_model
`default_nettype wire

// ### tb/afct_trigger_tb.sv
// Self-checking bench for the automatic flow-control trigger
`timescale 1ns/100ps
`default_nettype none
module afct_trigger_tb;
    logic                   clk, rst, cyc, stb, we, ack, err, fd, spd, txe, psent, bp, send, e, zt;
    logic [7:0]             adr;
    logic [3:0]             sel;
    logic [31:0]            dat, rdat, rs, q;
    logic [15:0]            lvl;
    logic [2:0]             dly;
    int                     n_errors, comparisons, n, h;
    afct_pkg::afct_rx_evt_t evt, sevt;
    afct_pkg::afct_pause_t  pause;
    afct_trigger dut (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
        .i_full_duplex(fd), .i_speed_100(spd), .i_tx_enable(txe), .i_rx_fifo_bytes(lvl), .i_rx_evt(evt),
        .o_pause(pause), .i_pause_sent(psent), .o_backpressure(bp));
    afct_mac_model peer (.i_clk_sys(clk), .i_rst(rst), .i_send(send), .i_evt(sevt), .i_delay(dly),
        .o_rx_evt(evt), .i_pause(pause), .o_pause_sent(psent));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Expected jam length in 100 ns cycles
    function automatic int dur_cyc(input int c, input logic s);
        int t[5] = '{50, 100, 150, 250, 500};
        int k;
        k = (c < 5) ? t[c] : (c - 3) * 500;
        return s ? k : k + 22;
    endfunction : dur_cyc
    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask : cmp_reg
    task automatic cmp_cnt(input int g, input int x);
        comparisons++;
        if (g != x) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask : cmp_cnt
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!(ack || err) && k < 20);
        q = rdat;
        e = err;
        // A bus that never answers ends the run at once
        if (!(ack || err)) begin
            n_errors++;
            tally_and_finish();
        end
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic frame(input logic [4:0] f);
        @(posedge clk);
        send <= 1'b1;
        sevt <= afct_pkg::afct_rx_evt_t'(f);
        @(posedge clk);
        send <= 1'b0;
    endtask : frame
    task automatic jam_len(input logic [4:0] f);
        int k;
        frame(f);
        n = 0;
        k = 0;
        while (bp !== 1'b1 && k < 12) begin
            @(posedge clk);
            k++;
        end
        while (bp === 1'b1 && n < 7000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 7000) begin
            n_errors++;
            tally_and_finish();
        end
    endtask : jam_len
    // Counts rising pause requests only, as a request stands until sent
    task automatic watch();
        logic p;
        p = 1'b0;
        h = 0;
        repeat (40) begin
            @(posedge clk);
            if (pause.req === 1'b1 && !p) begin
                h++;
                zt = pause.zero_time;
            end
            p = pause.req;
        end
    endtask : watch
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {cyc, stb, we, fd, txe, send, adr, sel, dat, lvl, dly, sevt} = '0;
        {spd, rst, n_errors, comparisons, rs} = {2'b11, 64'h0, 32'h7808};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        txe <= 1'b1;
        wb(1'b0, afct_pkg::ADDR_CONFIG, 32'h0, 4'hF);
        cmp_reg(q, afct_pkg::CONFIG_RESET);
        wb(1'b0, 8'h08, 32'h0, 4'hF);
        cmp_reg({31'h0, e}, 32'h1);
        rs = xs(rs);
        wb(1'b1, afct_pkg::ADDR_CONFIG, rs & 32'hFFFF_FFF0, 4'hF);
        wb(1'b1, afct_pkg::ADDR_CONFIG, ~rs & 32'hFFFF_FFF0, 4'h1);
        wb(1'b0, afct_pkg::ADDR_CONFIG, 32'h0, 4'hF);
        cmp_reg(q, {rs[31:8], ~rs[7:4], 4'h0} & afct_pkg::CONFIG_WMASK);
        $display("test registers done");
        lvl <= 16'h0080;
        for (int c = 0; c < 16; c++) begin
            spd <= ~c[0];
            wb(1'b1, afct_pkg::ADDR_CONFIG, {16'h0002, 8'h01, c[3:0], 4'h1}, 4'hF);
            jam_len(5'h10);
            cmp_cnt(n, dur_cyc(c, ~c[0]));
        end
        $display("test durations done");
        spd <= 1'b1;
        for (int b = 1; b < 4; b++) begin
            wb(1'b1, afct_pkg::ADDR_CONFIG, 32'h0002_0100 | (32'h1 << b), 4'hF);
            jam_len(5'h08 | (5'h1 << (b - 1)));
            cmp_cnt(n, 50);
            jam_len(5'h08 | (5'h1 << (b % 3)));
            cmp_cnt(n, 0);
        end
        wb(1'b1, afct_pkg::ADDR_CONFIG, 32'h0002_010F, 4'hF);
        // Any-frame waits for a preamble, so a decoded class match alone must not jam
        jam_len(5'h0F);
        cmp_cnt(n, 0);
        lvl <= 16'h007F;
        jam_len(5'h10);
        cmp_cnt(n, 0);
        $display("test classes done");
        dly <= rs[2:0];
        fd <= 1'b1;
        lvl <= 16'h0100;
        watch();
        cmp_cnt(h, 1);
        cmp_reg({31'h0, zt}, 32'h0);
        jam_len(5'h10);
        cmp_cnt(n, 0);
        watch();
        cmp_cnt(h, 0);
        lvl <= 16'h0010;
        watch();
        cmp_cnt(h, 1);
        cmp_reg({31'h0, zt}, 32'h1);
        txe <= 1'b0;
        lvl <= 16'h0100;
        watch();
        cmp_cnt(h, 0);
        fd <= 1'b0;
        jam_len(5'h10);
        cmp_cnt(n, 0);
        $display("test pause done");
        tally_and_finish();
    end
endmodule : afct_trigger_tb
bind afct_trigger afct_asserts chk (.i_clk_sys, .i_rst, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_wb_err,
    .i_full_duplex, .i_tx_enable, .i_rx_evt, .o_pause, .i_pause_sent, .o_backpressure);
`default_nettype wire
